// ### shared/simd_shuffle_move_pkg.sv
package simd_shuffle_move_pkg;

	// Operand and lane geometry of the vector datapath.
	localparam int VEC_W = 128;
	localparam int NARROW_W = 64;
	localparam int WORDS_PER_HALF = 4;
	localparam int DWORDS = 4;
	localparam int QWORDS = 2;
	localparam int BYTES = 16;

	// Operation codes presented by the issue logic.
	typedef enum logic [4:0] {
		OP_LO_WSHUF = 5'h00,
		OP_HI_WSHUF = 5'h01,
		OP_DW_SHUF = 5'h02,
		OP_BYTE_SHUF = 5'h03,
		OP_BLEND_IMM = 5'h04,
		OP_BLEND_REG = 5'h05,
		OP_UNPACK_LO = 5'h06,
		OP_UNPACK_HI = 5'h07,
		OP_N2W_MOVE = 5'h08,
		OP_W2N_MOVE = 5'h09,
		OP_EXTEND = 5'h0A,
		OP_ROUND = 5'h0B,
		OP_CVT_I2F = 5'h0C,
		OP_CVT_F2I = 5'h0D,
		OP_CMPEQ = 5'h0E,
		OP_XOR = 5'h0F,
		OP_SUBUS = 5'h10,
		OP_ABS = 5'h11,
		OP_SHL = 5'h12,
		OP_SHR = 5'h13
	} op_t;

	// Element size codes.
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_DWORD = 2'h2;
	localparam logic [1:0] SZ_QWORD = 2'h3;

	// Rounding mode codes, shared by the immediate and the csr field.
	localparam logic [1:0] RND_NEAREST = 2'h0;
	localparam logic [1:0] RND_DOWN = 2'h1;
	localparam logic [1:0] RND_UP = 2'h2;
	localparam logic [1:0] RND_TRUNC = 2'h3;

	// Immediate and byte shuffle control field positions.
	localparam int IMM_SEL_W = 2;
	localparam int IMM_RND_DBL = 0;
	localparam int IMM_RND_SCALAR = 1;
	localparam int IMM_RND_MODE = 2;
	localparam int SHUF_ZERO_POS = 7;
	localparam int SHUF_IDX_W = 4;

	// Floating-point format constants.
	localparam logic [5:0] SP_FRAC_W = 6'h17;
	localparam logic [5:0] DP_FRAC_W = 6'h34;
	localparam logic [10:0] SP_BIAS = 11'h07F;
	localparam logic [10:0] DP_BIAS = 11'h3FF;
	localparam logic [7:0] SP_EXP_ALL = 8'hFF;
	localparam logic [7:0] SP_EXP_INT_LSB = 8'h96;
	localparam logic [7:0] SP_EXP_INT_OVF = 8'h9E;
	localparam logic [31:0] INT_INDEFINITE = 32'h80000000;

	// Registered state of the unit and its value after reset.
	typedef struct packed {
		logic valid;
		logic illegal;
		logic [VEC_W-1:0] result;
		logic [NARROW_W-1:0] narrow;
	} state_t;

	localparam state_t STATE_RESET = '0;

endpackage

// ### verilog/simd_shuffle_move_unit.sv
`timescale 1ns/1ps

// Contract
// - Half word shuffle: any word to any word.
// - Other 64-bit half copied through unchanged.
// - Dword shuffle routes any dword anywhere.
// - Byte shuffle stays inside 16 bytes.
// - Blend copies selected, keeps unselected destination.
// - Blend mask from immediate or mask register.
// - Quadword unpack interleaves low or high halves.
// - Unused halves of both operands ignored.
// - Narrow to wide move zeroes upper half.
// - Wide to narrow move takes low half.
// - Sign or zero widening of packed integers.
// - Rounding mode from immediate, not csr.
// - Rounded integral values stay floating point.
// - Four singles to or from four dwords.
// - Compare-equal of self gives all ones.
// - Exclusive-or of self gives zero.
// - Shifts only at word and dword size.
// - Unsigned saturating subtract: bytes and words only.
// - Absolute value on bytes, words, dwords.
// - Absolute value of 8000H stays 8000H.
module simd_shuffle_move_unit
	import simd_shuffle_move_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_valid,
	input wire op_t i_op,
	input wire logic [1:0] i_size,
	input wire logic i_sign,
	input wire logic [7:0] i_imm,
	input wire logic [VEC_W-1:0] i_src_a,
	input wire logic [VEC_W-1:0] i_src_b,
	input wire logic [VEC_W-1:0] i_mask_reg,
	input wire logic [NARROW_W-1:0] i_narrow_src,
	input wire logic [1:0] i_fp_csr_round,
	output logic o_valid,
	output logic o_illegal,
	output logic [VEC_W-1:0] o_result,
	output logic [NARROW_W-1:0] o_narrow_result
);

	state_t st_q;
	state_t st_d;

	// Rounds a single (dbl low) or double to an integral value, kept in
	// floating-point form. Carry out of the fraction walks into the
	// exponent on its own, so no renormalising step is needed.
	function automatic logic [63:0] round_fp(input logic [63:0] x,
			input logic dbl, input logic [1:0] mode);
		logic sgn;
		logic inc;
		logic [5:0] fw;
		logic [5:0] nf;
		logic [10:0] bias;
		logic [10:0] ex;
		logic [62:0] mag;
		logic [62:0] one;
		logic [62:0] msk;
		logic [62:0] frac;
		logic [62:0] res;
		fw = dbl ? DP_FRAC_W : SP_FRAC_W;
		bias = dbl ? DP_BIAS : SP_BIAS;
		sgn = dbl ? x[63] : x[31];
		mag = dbl ? x[62:0] : {32'h00000000, x[30:0]};
		ex = 11'(mag >> fw);
		inc = 1'b0;
		res = mag;
		if (ex >= bias + {5'h00, fw}) begin
			res = mag;
		end else if (ex < bias) begin
			case (mode)
				RND_NEAREST: inc = (ex == bias - 11'h001) &&
					((mag & ((63'h1 << fw) - 63'h1)) != '0);
				RND_DOWN: inc = sgn;
				RND_UP: inc = !sgn;
				default: inc = 1'b0;
			endcase
			if (mag == '0) begin
				inc = 1'b0;
			end
			res = inc ? (63'(bias) << fw) : '0;
		end else begin
			nf = 6'(11'(fw) + bias - ex);
			one = 63'h1 << nf;
			msk = one - 63'h1;
			frac = mag & msk;
			case (mode)
				RND_NEAREST: inc = (frac > (one >> 1)) ||
					((frac == (one >> 1)) && ((mag & one) != '0));
				RND_DOWN: inc = sgn && (frac != '0);
				RND_UP: inc = !sgn && (frac != '0);
				default: inc = 1'b0;
			endcase
			res = (mag & ~msk) + (inc ? one : '0);
		end
		return dbl ? {sgn, res} : {32'h00000000, sgn, res[30:0]};
	endfunction

	// Single to dword; out of range gives the integer indefinite value.
	function automatic logic [31:0] float_to_int(input logic [31:0] x,
			input logic [1:0] mode);
		logic [63:0] rr;
		logic [7:0] e;
		logic [31:0] m;
		logic [31:0] mag;
		rr = round_fp({32'h00000000, x}, 1'b0, mode);
		e = rr[30:23];
		m = {8'h00, 1'b1, rr[22:0]};
		mag = (e >= SP_EXP_INT_LSB) ? (m << (e - SP_EXP_INT_LSB)) :
			(m >> (SP_EXP_INT_LSB - e));
		if (e == SP_EXP_ALL || e >= SP_EXP_INT_OVF) begin
			return INT_INDEFINITE;
		end else if (e < 8'(SP_BIAS)) begin
			return 32'h00000000;
		end
		return rr[31] ? -mag : mag;
	endfunction

	// Dword to single, rounded in the given mode.
	function automatic logic [31:0] int_to_float(input logic [31:0] v,
			input logic [1:0] mode);
		logic sgn;
		logic inc;
		logic [4:0] top;
		logic [31:0] a;
		logic [31:0] n;
		logic [30:0] body;
		sgn = v[31];
		a = sgn ? -v : v;
		top = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (a[i]) begin
				top = 5'(i);
			end
		end
		n = a << (5'h1F - top);
		case (mode)
			RND_NEAREST: inc = (n[7:0] > 8'h80) ||
				((n[7:0] == 8'h80) && n[8]);
			RND_DOWN: inc = sgn && (n[7:0] != 8'h00);
			RND_UP: inc = !sgn && (n[7:0] != 8'h00);
			default: inc = 1'b0;
		endcase
		body = {8'(SP_BIAS) + {3'h0, top}, n[30:8]} + {30'h0, inc};
		return (a == '0) ? 32'h00000000 : {sgn, body};
	endfunction

	// Widens the low element of x from size ss to 64 bits.
	function automatic logic [63:0] widen(input logic [127:0] x,
			input logic [1:0] ss, input logic sgn);
		case (ss)
			SZ_BYTE: return {{56{sgn & x[7]}}, x[7:0]};
			SZ_WORD: return {{48{sgn & x[15]}}, x[15:0]};
			default: return {{32{sgn & x[31]}}, x[31:0]};
		endcase
	endfunction

	// Result selection. Operand a is the destination, b the source.
	always_comb begin
		logic [VEC_W-1:0] r;
		logic [NARROW_W-1:0] n;
		logic [63:0] t;
		logic bad;
		r = '0;
		n = '0;
		t = '0;
		bad = 1'b0;
		st_d = st_q;
		st_d.valid = i_valid;
		st_d.illegal = 1'b0;
		case (i_op)
			OP_LO_WSHUF: begin
				r[127:64] = i_src_b[127:64];
				for (int i = 0; i < WORDS_PER_HALF; i++) begin
					r[16*i +: 16] = i_src_b[16*i_imm[2*i +: IMM_SEL_W] +: 16];
				end
			end
			OP_HI_WSHUF: begin
				r[63:0] = i_src_b[63:0];
				for (int i = 0; i < WORDS_PER_HALF; i++) begin
					r[64+16*i +: 16] =
						i_src_b[64+16*i_imm[2*i +: IMM_SEL_W] +: 16];
				end
			end
			OP_DW_SHUF: begin
				for (int i = 0; i < DWORDS; i++) begin
					r[32*i +: 32] = i_src_b[32*i_imm[2*i +: IMM_SEL_W] +: 32];
				end
			end
			OP_BYTE_SHUF: begin
				// Only four index bits are used, so no byte can come from
				// outside the register.
				for (int i = 0; i < BYTES; i++) begin
					if (!i_src_b[8*i+SHUF_ZERO_POS]) begin
						r[8*i +: 8] = i_src_a[8*i_src_b[8*i +: SHUF_IDX_W] +: 8];
					end
				end
			end
			OP_BLEND_IMM: begin
				for (int i = 0; i < 8; i++) begin
					r[16*i +: 16] = i_imm[i] ? i_src_b[16*i +: 16] :
						i_src_a[16*i +: 16];
				end
			end
			OP_BLEND_REG: begin
				for (int i = 0; i < BYTES; i++) begin
					r[8*i +: 8] = i_mask_reg[8*i+7] ? i_src_b[8*i +: 8] :
						i_src_a[8*i +: 8];
				end
			end
			OP_UNPACK_LO: r = {i_src_b[63:0], i_src_a[63:0]};
			OP_UNPACK_HI: r = {i_src_b[127:64], i_src_a[127:64]};
			OP_N2W_MOVE: r = {64'h0000000000000000, i_narrow_src};
			OP_W2N_MOVE: n = i_src_a[63:0];
			OP_EXTEND: begin
				// Size holds the wider result size, imm the source size.
				bad = (i_size <= i_imm[1:0]) || (i_imm[1:0] == SZ_QWORD);
				for (int k = 0; k < 8; k++) begin
					t = widen(i_src_b >> (k << (3 + i_imm[1:0])), i_imm[1:0],
						i_sign);
					case (i_size)
						SZ_WORD: r[16*k +: 16] = t[15:0];
						SZ_DWORD: if (k < DWORDS) r[32*k +: 32] = t[31:0];
						default: if (k < QWORDS) r[64*k +: 64] = t;
					endcase
				end
				if (bad) begin
					r = '0;
				end
			end
			OP_ROUND: begin
				// The csr mode is not consulted here on purpose.
				r = i_src_a;
				for (int j = 0; j < DWORDS; j++) begin
					if (i_imm[IMM_RND_DBL] && j < QWORDS) begin
						if (!i_imm[IMM_RND_SCALAR] || j == 0) begin
							r[64*j +: 64] = round_fp(i_src_b[64*j +: 64], 1'b1,
								i_imm[IMM_RND_MODE +: 2]);
						end
					end else if (!i_imm[IMM_RND_DBL]) begin
						if (!i_imm[IMM_RND_SCALAR] || j == 0) begin
							t = round_fp({32'h00000000, i_src_b[32*j +: 32]}, 1'b0,
								i_imm[IMM_RND_MODE +: 2]);
							r[32*j +: 32] = t[31:0];
						end
					end
				end
			end
			OP_CVT_I2F: begin
				for (int j = 0; j < DWORDS; j++) begin
					r[32*j +: 32] = int_to_float(i_src_b[32*j +: 32],
						i_fp_csr_round);
				end
			end
			OP_CVT_F2I: begin
				for (int j = 0; j < DWORDS; j++) begin
					r[32*j +: 32] = float_to_int(i_src_b[32*j +: 32],
						i_fp_csr_round);
				end
			end
			OP_CMPEQ: begin
				for (int i = 0; i < BYTES; i++) begin
					case (i_size)
						SZ_BYTE: r[8*i +: 8] = {8{i_src_a[8*i +: 8] ==
							i_src_b[8*i +: 8]}};
						SZ_WORD: r[8*i +: 8] = {8{i_src_a[16*(i/2) +: 16] ==
							i_src_b[16*(i/2) +: 16]}};
						SZ_DWORD: r[8*i +: 8] = {8{i_src_a[32*(i/4) +: 32] ==
							i_src_b[32*(i/4) +: 32]}};
						default: r[8*i +: 8] = {8{i_src_a[64*(i/8) +: 64] ==
							i_src_b[64*(i/8) +: 64]}};
					endcase
				end
			end
			OP_XOR: r = i_src_a ^ i_src_b;
			OP_SUBUS: begin
				bad = (i_size != SZ_BYTE) && (i_size != SZ_WORD);
				for (int i = 0; i < BYTES; i++) begin
					if (i_size == SZ_BYTE) begin
						r[8*i +: 8] = (i_src_a[8*i +: 8] > i_src_b[8*i +: 8]) ?
							i_src_a[8*i +: 8] - i_src_b[8*i +: 8] : 8'h00;
					end else if (i_size == SZ_WORD && i < 8) begin
						r[16*i +: 16] = (i_src_a[16*i +: 16] > i_src_b[16*i +: 16]) ?
							i_src_a[16*i +: 16] - i_src_b[16*i +: 16] : 16'h0000;
					end
				end
			end
			OP_ABS: begin
				// Negation wraps, so the most negative value comes back as is.
				bad = (i_size == SZ_QWORD);
				for (int i = 0; i < BYTES; i++) begin
					case (i_size)
						SZ_BYTE: r[8*i +: 8] = i_src_b[8*i+7] ?
							-i_src_b[8*i +: 8] : i_src_b[8*i +: 8];
						SZ_WORD: if (i < 8) r[16*i +: 16] = i_src_b[16*i+15] ?
							-i_src_b[16*i +: 16] : i_src_b[16*i +: 16];
						SZ_DWORD: if (i < DWORDS) r[32*i +: 32] = i_src_b[32*i+31] ?
							-i_src_b[32*i +: 32] : i_src_b[32*i +: 32];
						default: r = '0;
					endcase
				end
			end
			OP_SHL, OP_SHR: begin
				// Counts past the element width give zero, or all sign bits.
				bad = (i_size != SZ_WORD) && (i_size != SZ_DWORD);
				for (int i = 0; i < 8; i++) begin
					if (i_size == SZ_WORD) begin
						r[16*i +: 16] = (i_op == OP_SHL) ? i_src_b[16*i +: 16] << i_imm :
							i_sign ? 16'($signed(i_src_b[16*i +: 16]) >>> i_imm) :
							i_src_b[16*i +: 16] >> i_imm;
					end else if (i_size == SZ_DWORD && i < DWORDS) begin
						r[32*i +: 32] = (i_op == OP_SHL) ? i_src_b[32*i +: 32] << i_imm :
							i_sign ? 32'($signed(i_src_b[32*i +: 32]) >>> i_imm) :
							i_src_b[32*i +: 32] >> i_imm;
					end
				end
			end
			default: bad = 1'b1;
		endcase
		if (i_valid) begin
			st_d.illegal = bad;
			st_d.result = bad ? '0 : r;
			st_d.narrow = n;
		end
	end

	// One flop stage: every answer appears one cycle after issue.
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_q <= STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_valid = st_q.valid;
	assign o_illegal = st_q.illegal;
	assign o_result = st_q.result;
	assign o_narrow_result = st_q.narrow;

	// Copies of the issued operands, read only by the checks below.
	logic [VEC_W-1:0] chk_a_q;
	logic [VEC_W-1:0] chk_b_q;
	logic [7:0] chk_imm_q;
	logic [NARROW_W-1:0] chk_narrow_q;

	always_ff @(posedge i_core_clk) begin
		chk_a_q <= i_src_a;
		chk_b_q <= i_src_b;
		chk_imm_q <= i_imm;
		chk_narrow_q <= i_narrow_src;
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence s_take(op_t op);
		i_valid && i_op == op;
	endsequence

	sequence s_answer;
		o_valid && !o_illegal;
	endsequence

	AST_LO_SHUF: assert property (s_take(OP_LO_WSHUF) |=> s_answer ##0
		o_result[15:0] == chk_b_q[16*chk_imm_q[1:0] +: 16])
		else $error("low word shuffle picked the wrong word");

	AST_LO_SHUF_PASS: assert property (s_take(OP_LO_WSHUF) |=>
		o_result[127:64] == chk_b_q[127:64])
		else $error("upper half not passed through");

	AST_DW_SHUF: assert property (s_take(OP_DW_SHUF) |=>
		o_result[127:96] == chk_b_q[32*chk_imm_q[7:6] +: 32])
		else $error("dword shuffle top lane wrong");

	AST_BYTE_SHUF: assert property (s_take(OP_BYTE_SHUF) &&
		i_src_b[7:0] == 8'h0F |=> o_result[7:0] == chk_a_q[127:120])
		else $error("byte shuffle index 15 wrong");

	AST_BLEND_KEEP: assert property (s_take(OP_BLEND_REG) &&
		!i_mask_reg[7] |=> o_result[7:0] == chk_a_q[7:0])
		else $error("unselected blend byte changed");

	AST_UNPACK_LO: assert property (s_take(OP_UNPACK_LO) |=>
		o_result == {chk_b_q[63:0], chk_a_q[63:0]})
		else $error("low quadword unpack wrong");

	AST_N2W: assert property (s_take(OP_N2W_MOVE) |=> s_answer ##0
		o_result == {64'h0000000000000000, chk_narrow_q})
		else $error("narrow to wide move wrong");

	AST_W2N: assert property (s_take(OP_W2N_MOVE) |=>
		o_narrow_result == chk_a_q[63:0])
		else $error("wide to narrow move wrong");

	AST_EXTEND: assert property (s_take(OP_EXTEND) && i_size == SZ_WORD &&
		i_imm[1:0] == SZ_BYTE && i_sign && i_src_b[7:0] == 8'h80 |=>
		o_result[15:0] == 16'hFF80)
		else $error("sign extension of byte wrong");

	AST_ROUND_OWN_MODE: assert property (s_take(OP_ROUND) &&
		i_imm[3:0] == 4'hC && i_src_b[95:64] == 32'h3FC00000 |=>
		o_result[95:64] == 32'h3F800000)
		else $error("rounding ignored its own mode");

	AST_I2F: assert property (s_take(OP_CVT_I2F) &&
		i_src_b[31:0] == 32'h00000001 |=> o_result[31:0] == 32'h3F800000)
		else $error("dword one did not convert to 1.0");

	AST_CMPEQ_SELF: assert property (s_take(OP_CMPEQ) &&
		i_src_a == i_src_b |=> o_result == {VEC_W{1'b1}})
		else $error("self compare not all ones");

	AST_XOR_SELF: assert property (s_take(OP_XOR) &&
		i_src_a == i_src_b |=> o_result == '0)
		else $error("self xor not zero");

	AST_SHIFT_BYTE: assert property (s_take(OP_SHL) && i_size == SZ_BYTE
		|=> o_valid && o_illegal)
		else $error("byte shift not refused");

	AST_SUBUS_DWORD: assert property (s_take(OP_SUBUS) &&
		i_size == SZ_DWORD |=> o_illegal)
		else $error("dword saturating subtract not refused");

	AST_SUBUS_CLAMP: assert property (s_take(OP_SUBUS) && i_size == SZ_BYTE
		&& i_src_a[7:0] < i_src_b[7:0] |=> o_result[7:0] == 8'h00)
		else $error("saturating subtract did not clamp");

	AST_ABS_MIN: assert property (s_take(OP_ABS) && i_size == SZ_WORD &&
		i_src_b[15:0] == 16'h8000 |=> o_result[15:0] == 16'h8000)
		else $error("abs of most negative word changed");

endmodule

// ### dv/core_writeback_model.sv
`timescale 1ns/1ps

// Writeback side of the issue logic: a one-entry register file.
module core_writeback_model (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_issue,
	input wire logic i_done,
	input wire logic i_illegal,
	input wire logic [127:0] i_result,
	output logic [127:0] o_rf_q,
	output logic o_late_q
);
	logic issued_q;

	// A result that arrives in any cycle other than the one after an issue is
	// flagged, because the register file would then take a stale value.
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			issued_q <= 1'b0;
			o_rf_q <= '0;
			o_late_q <= 1'b0;
		end else begin
			issued_q <= i_issue;
			if (i_done && !i_illegal) begin
				o_rf_q <= i_result;
			end
			if (i_done != issued_q) begin
				o_late_q <= 1'b1;
			end
		end
	end
endmodule

// ### dv/test_simd_shuffle_move_unit.sv
`timescale 1ns/1ps

module test_simd_shuffle_move_unit
	import simd_shuffle_move_pkg::*;
;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic valid = 1'b0;
	op_t op = OP_XOR;
	logic [1:0] sz = 2'h0;
	logic sign = 1'b0;
	logic [7:0] imm = 8'h00;
	logic [127:0] a = '0;
	logic [127:0] b = '0;
	logic [127:0] m = '0;
	logic [63:0] nar = '0;
	logic [1:0] csr = 2'h0;
	logic ov, oill, late;
	logic [127:0] ores, rf, x, y;
	logic [63:0] onar;
	int fail_count = 0;
	int num_checks = 0;
	op_t ops[$] = '{OP_LO_WSHUF, OP_HI_WSHUF, OP_DW_SHUF, OP_BYTE_SHUF,
		OP_BLEND_IMM, OP_BLEND_REG, OP_UNPACK_LO, OP_UNPACK_HI, OP_N2W_MOVE,
		OP_EXTEND, OP_CMPEQ, OP_XOR, OP_SUBUS, OP_ABS, OP_SHL, OP_SHR};
	logic [127:0] rnd_exp[4] = '{{32'hC0000000, 32'h40000000, 32'hC0000000,
		32'h40000000}, {32'hC0000000, 32'h3F800000, 32'hC0400000,
		32'h40000000}, {32'hBF800000, 32'h40000000, 32'hC0000000,
		32'h40400000}, {32'hBF800000, 32'h3F800000, 32'hC0000000,
		32'h40000000}};

	always #5 core_clk = ~core_clk;

	simd_shuffle_move_unit simd_shuffle_move_unit_i (.i_core_clk(core_clk),
		.i_srst(srst), .i_valid(valid), .i_op(op), .i_size(sz),
		.i_sign(sign), .i_imm(imm), .i_src_a(a), .i_src_b(b),
		.i_mask_reg(m), .i_narrow_src(nar), .i_fp_csr_round(csr),
		.o_valid(ov), .o_illegal(oill), .o_result(ores),
		.o_narrow_result(onar));

	core_writeback_model core_writeback_model_i (.i_core_clk(core_clk),
		.i_srst(srst), .i_issue(valid), .i_done(ov), .i_illegal(oill),
		.i_result(ores), .o_rf_q(rf), .o_late_q(late));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [127:0] rv();
		return {$urandom, $urandom, $urandom, $urandom};
	endfunction

	// Element j of width w, zero padded to 64 bits.
	function automatic logic [63:0] elt(logic [127:0] v, int j, int w);
		return 64'(v >> (j * w)) & ((64'h1 << w) - 64'h1);
	endfunction

	// Expected {illegal, result} of one operation.
	function automatic logic [128:0] expect_op(op_t o, logic [1:0] s,
		logic g, logic [7:0] im, logic [127:0] p, q, mk, logic [63:0] n);
		logic [127:0] r;
		logic [63:0] e, f, d;
		logic signed [63:0] t;
		logic bad;
		int w, v;
		r = q;
		w = 8 << s;
		v = 8 << im[1:0];
		bad = (o == OP_SUBUS && s > SZ_WORD) || (o == OP_ABS && s == SZ_QWORD)
			|| ((o == OP_SHL || o == OP_SHR) && (s == SZ_BYTE || s == SZ_QWORD))
			|| (o == OP_EXTEND && (s <= im[1:0] || im[1:0] == SZ_QWORD));
		case (o)
			OP_LO_WSHUF: for (int i = 0; i < 4; i++)
				r[16*i+:16] = q[16*im[2*i+:2]+:16];
			OP_HI_WSHUF: for (int i = 0; i < 4; i++)
				r[64+16*i+:16] = q[64+16*im[2*i+:2]+:16];
			OP_DW_SHUF: for (int i = 0; i < 4; i++)
				r[32*i+:32] = q[32*im[2*i+:2]+:32];
			OP_BYTE_SHUF: for (int i = 0; i < 16; i++)
				r[8*i+:8] = q[8*i+7] ? 8'h00 : p[8*q[8*i+:4]+:8];
			OP_BLEND_IMM: for (int i = 0; i < 8; i++)
				r[16*i+:16] = im[i] ? q[16*i+:16] : p[16*i+:16];
			OP_BLEND_REG: for (int i = 0; i < 16; i++)
				r[8*i+:8] = mk[8*i+7] ? q[8*i+:8] : p[8*i+:8];
			OP_UNPACK_LO: r = {q[63:0], p[63:0]};
			OP_UNPACK_HI: r = {q[127:64], p[127:64]};
			OP_N2W_MOVE: r = {64'h0, n};
			OP_XOR: r = p ^ q;
			OP_EXTEND, OP_CMPEQ, OP_SUBUS, OP_ABS, OP_SHL, OP_SHR: begin
				for (int j = 0; j < 128 / w; j++) begin
					e = elt(p, j, w);
					f = elt(q, j, w);
					t = g ? signed'(f << (64 - w)) >>> (64 - w) : signed'(f);
					case (o)
						OP_CMPEQ: d = (e == f) ? '1 : '0;
						OP_SUBUS: d = (e > f) ? e - f : 64'h0;
						OP_ABS: d = f[w-1] ? -f : f;
						OP_SHL: d = f << im;
						OP_SHR: d = t >>> im;
						default: begin
							f = elt(q, j, v);
							t = signed'(f << (64 - v)) >>> (64 - v);
							d = g ? t : f;
						end
					endcase
					for (int k = 0; k < w; k++)
						r[j*w+k] = d[k];
				end
			end
			default: bad = 1'b1;
		endcase
		return bad ? {1'b1, 128'h0} : {1'b0, r};
	endfunction

	// One issue strobe; the answer is looked at in the cycle it stands.
	task automatic issue(op_t o, logic [1:0] s, logic g, logic [7:0] im,
		logic [127:0] p, q, mk, logic [63:0] n, logic [1:0] c);
		@(posedge core_clk);
		valid <= 1'b1;
		op <= o;
		sz <= s;
		sign <= g;
		imm <= im;
		a <= p;
		b <= q;
		m <= mk;
		nar <= n;
		csr <= c;
		@(posedge core_clk);
		valid <= 1'b0;
		#1;
		chk(ov, 1'b1);
	endtask

	task automatic run(op_t o, logic [1:0] s, logic g, logic [7:0] im,
		logic [127:0] p, q, mk, logic [63:0] n);
		logic [128:0] e;
		e = expect_op(o, s, g, im, p, q, mk, n);
		issue(o, s, g, im, p, q, mk, n, 2'($urandom));
		chk({oill, ores}, e);
		chk(onar, 64'h0);
		@(posedge core_clk);
		#1;
		// The answer strobe stands for a single cycle only.
		chk(ov, 1'b0);
		if (!e[128])
			chk(rf, e[127:0]);
	endtask

	// Cuts a hang short well past the length of the whole sequence.
	initial begin
		#500000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(32'h3F0A));
		repeat (5) @(posedge core_clk);
		#1;
		chk({ov, oill, ores, onar}, '0);
		@(posedge core_clk);
		srst <= 1'b0;
		x = rv();
		run(OP_XOR, SZ_BYTE, 1'b0, 8'h00, x, x, rv(), 64'h0);
		for (int s = 0; s < 4; s++)
			run(OP_CMPEQ, 2'(s), 1'b0, 8'h00, x, x, x, 64'h0);
		run(OP_ABS, SZ_WORD, 1'b0, 8'h00, x, {8{16'h8000}}, x, 64'h0);
		run(OP_SUBUS, SZ_DWORD, 1'b0, 8'h00, x, rv(), x, 64'h0);
		run(OP_SHL, SZ_BYTE, 1'b0, 8'h01, x, rv(), x, 64'h0);
		run(OP_SHR, SZ_WORD, 1'b1, 8'h03, x, rv(), x, 64'h0);
		run(OP_SHL, SZ_DWORD, 1'b0, 8'h05, x, rv(), x, 64'h0);
		run(OP_N2W_MOVE, SZ_BYTE, 1'b0, 8'h00, x, x, x, 64'($urandom));
		run(op_t'(5'h1F), SZ_BYTE, 1'b0, 8'h00, x, x, x, 64'h0);
		issue(OP_W2N_MOVE, SZ_BYTE, 1'b0, 8'h00, x, rv(), x, 64'h0, 2'h0);
		chk(onar, x[63:0]);
		// Lanes 2.5, -2.5, 1.5, -1.5; the csr asks for another mode each time.
		for (int md = 0; md < 4; md++) begin
			issue(OP_ROUND, SZ_DWORD, 1'b0, 8'({md[1:0], 2'h0}), x,
				{32'hBFC00000, 32'h3FC00000, 32'hC0200000, 32'h40200000}, x,
				64'h0, 2'(md) ^ 2'h3);
			chk(ores, rnd_exp[md]);
		end
		// Scalar double, rounding up: 2.5 becomes 3.0, upper lane from a.
		issue(OP_ROUND, SZ_QWORD, 1'b0, 8'h0B, x,
			{64'hC004000000000000, 64'h4004000000000000}, x, 64'h0, 2'h1);
		chk(ores, {x[127:64], 64'h4008000000000000});
		issue(OP_CVT_I2F, SZ_DWORD, 1'b0, 8'h00, x,
			{32'h4, 32'h3, 32'h2, 32'h1}, x, 64'h0, 2'h0);
		chk(ores, {32'h40800000, 32'h40400000, 32'h40000000, 32'h3F800000});
		issue(OP_CVT_F2I, SZ_DWORD, 1'b0, 8'h00, x,
			{32'h40800000, 32'h40400000, 32'h40000000, 32'h3F800000}, x,
			64'h0, 2'h1);
		chk(ores, {32'h4, 32'h3, 32'h2, 32'h1});
		// Random mix; a quarter of the draws give both operands the same value.
		repeat (300) begin
			x = rv();
			y = ($urandom % 4 == 0) ? x : rv();
			run(ops[$urandom % ops.size()], 2'($urandom), 1'($urandom),
				8'($urandom), x, y, rv(), 64'($urandom));
		end
		chk(late, 1'b0);
		tally_and_finish();
	end
endmodule
